// file: hdl/lac_customer_end.sv
// customer side transceiver: active signal, layer2 ready bit and transparent loop
`timescale 1ns/1ps
module lac_customer_end #(
    parameter logic [31:0] P_WARM_BUDGET_CYC = lac_pkg::WARM_SIDE_CYC,
    parameter logic [31:0] P_COLD_BUDGET_CYC = lac_pkg::COLD_CUST_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    lac_link_if.cust link,
    input wire logic loop_enable,
    input wire logic term_active,
    input wire logic layer2_ready,
    input wire logic warm_start,
    input wire logic [lac_pkg::BD_W-1:0] tx_bd,
    input wire logic [lac_pkg::M_W-1:0] tx_maint,
    output logic tx_taken,
    output logic te_valid,
    input wire logic te_ready,
    output logic [lac_pkg::BD_W-1:0] te_bd,
    output logic te_info4,
    output logic synchronised,
    output logic loop_closed,
    output logic budget_overrun
);
    import lac_pkg::*;

    typedef enum logic [2:0] {
        CUST_IDLE_STATE,
        CUST_ACQUIRING_STATE,
        CUSTOMER_SYNCHRONISED_STATE,
        CUST_ACTIVE_STATE,
        CUST_LOOP_PENDING_STATE,
        CUST_LOOP_CLOSED_STATE
    } lac_cu_state_t;

    lac_cu_state_t st_reg, st_next;
    logic [1:0] cnt_reg, cnt_next;
    logic [1:0] conf_reg, conf_next;
    logic [31:0] bud_reg, bud_next;
    logic over_reg, over_next;
    logic info4_reg, info4_next;
    logic up_valid_reg, up_valid_next;
    lac_word_t up_word_reg, up_word_next;
    lac_word_t fifo_mem_reg [2];
    lac_word_t fifo_mem_next [2];
    logic wr_idx_reg, wr_idx_next;
    logic rd_idx_reg, rd_idx_next;
    logic [1:0] fill_reg, fill_next;
    lac_word_t head, loop_word;
    logic push, pop, head_valid, looped, up_acc, present, transparent;
    logic [31:0] budget;

    // two-entry buffer on the downstream path; a stalled drain backs up to the exchange
    assign link.dn_ready = (fill_reg != FIFO_DEPTH);
    assign push = link.dn_valid && link.dn_ready;
    assign head = fifo_mem_reg[rd_idx_reg];
    assign head_valid = (fill_reg != 2'h0);
    assign looped = (st_reg == CUST_LOOP_CLOSED_STATE);
    assign present = push && (link.dn_word.sig != LAC_SIG_NONE);
    assign transparent = term_active && layer2_ready;
    assign budget = warm_start ? P_WARM_BUDGET_CYC : P_COLD_BUDGET_CYC;

    always_comb begin
        loop_word = up_word_reg;
        loop_word.sig = LAC_SIG_ACTIVE;
        loop_word.layer2_ready_bit = 1'b1;
        loop_word.keep_on = 1'b1;
        loop_word.loop_cmd = 1'b0;
        loop_word.bd = head.bd;
    end

    // while looped the upstream stream is the buffer itself
    assign link.up_valid = looped ? head_valid : up_valid_reg;
    assign link.up_word = looped ? loop_word : up_word_reg;
    assign up_acc = link.up_valid && link.up_ready;
    // looped words drain upstream; the terminal sees a copy and cannot stall the loop
    assign pop = head_valid && (looped ? up_acc : te_ready);

    always_comb begin
        fifo_mem_next = fifo_mem_reg;
        wr_idx_next = wr_idx_reg;
        rd_idx_next = rd_idx_reg;
        fill_next = fill_reg;
        if (push) begin
            fifo_mem_next[wr_idx_reg] = link.dn_word;
            wr_idx_next = !wr_idx_reg;
        end
        if (pop) begin
            rd_idx_next = !rd_idx_reg;
        end
        if (push && !pop) begin
            fill_next = fill_reg + 2'h1;
        end else if (pop && !push) begin
            fill_next = fill_reg - 2'h1;
        end
    end

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        conf_next = conf_reg;
        bud_next = bud_reg;
        over_next = 1'b0;
        if (st_reg == CUST_ACQUIRING_STATE && bud_reg != 32'hffffffff) begin
            bud_next = bud_reg + 32'h1;
            over_next = (bud_reg == budget);
        end
        if (st_reg inside {CUSTOMER_SYNCHRONISED_STATE, CUST_ACTIVE_STATE} && push) begin
            if (link.dn_word.loop_cmd && loop_enable) begin
                conf_next = conf_reg + 2'h1;
            end else begin
                conf_next = 2'h0;
            end
        end
        case (st_reg)
            CUST_IDLE_STATE: begin
                if (present) begin
                    st_next = CUST_ACQUIRING_STATE;
                    cnt_next = 2'h0;
                    bud_next = 32'h0;
                    conf_next = 2'h0;
                end
            end
            CUST_ACQUIRING_STATE: begin
                if (present) begin
                    cnt_next = cnt_reg + 2'h1;
                    if (cnt_reg == SYNC_WORDS - 2'h1) begin
                        st_next = CUSTOMER_SYNCHRONISED_STATE;
                    end
                end
            end
            CUSTOMER_SYNCHRONISED_STATE, CUST_ACTIVE_STATE: begin
                if (push && link.dn_word.loop_cmd && loop_enable && conf_reg == CONFIRM_WORDS - 2'h1) begin
                    st_next = CUST_LOOP_PENDING_STATE;
                end else if (st_reg == CUSTOMER_SYNCHRONISED_STATE && transparent) begin
                    st_next = CUST_ACTIVE_STATE;
                end else if (st_reg == CUST_ACTIVE_STATE && !transparent) begin
                    st_next = CUSTOMER_SYNCHRONISED_STATE;
                end
            end
            CUST_LOOP_PENDING_STATE: begin
                if (!loop_enable || (push && !link.dn_word.loop_cmd)) begin
                    st_next = CUSTOMER_SYNCHRONISED_STATE;
                end else if (push && link.dn_word.sig == LAC_SIG_ACTIVE) begin
                    st_next = CUST_LOOP_CLOSED_STATE;
                end
            end
            CUST_LOOP_CLOSED_STATE: begin
                if (!loop_enable || (push && !link.dn_word.loop_cmd)) begin
                    st_next = CUSTOMER_SYNCHRONISED_STATE;
                end
            end
            default: begin
                st_next = CUST_IDLE_STATE;
            end
        endcase
        // a silent word downstream means the line dropped
        if (st_reg != CUST_IDLE_STATE && push && link.dn_word.sig == LAC_SIG_NONE) begin
            st_next = CUST_IDLE_STATE;
        end
        if (st_next inside {CUST_IDLE_STATE, CUST_ACQUIRING_STATE, CUST_LOOP_PENDING_STATE,
            CUST_LOOP_CLOSED_STATE}) begin
            conf_next = 2'h0;
        end
    end

    // terminal info4 starts with the upstream active signal, idle terminal stays on info2
    always_comb begin
        info4_next = (st_next == CUST_ACTIVE_STATE) ||
            ((st_next inside {CUST_LOOP_PENDING_STATE, CUST_LOOP_CLOSED_STATE}) && term_active);
    end

    // own upstream word; refreshed during the loop so own maintenance bits stay current
    always_comb begin
        up_valid_next = up_valid_reg;
        up_word_next = up_word_reg;
        if (!up_valid_reg || looped || up_acc) begin
            up_valid_next = (st_next != CUST_IDLE_STATE);
            up_word_next.sig = (st_next inside {CUST_ACTIVE_STATE, CUST_LOOP_PENDING_STATE,
                CUST_LOOP_CLOSED_STATE}) ? LAC_SIG_ACTIVE : LAC_SIG_SYNC;
            up_word_next.layer2_ready_bit = st_next inside {CUST_ACTIVE_STATE, CUST_LOOP_PENDING_STATE,
                CUST_LOOP_CLOSED_STATE};
            up_word_next.keep_on = 1'b1;
            up_word_next.loop_cmd = 1'b0;
            up_word_next.bd = tx_bd;
            up_word_next.maint = tx_maint;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_reg <= CUST_IDLE_STATE;
            cnt_reg <= 2'h0;
            conf_reg <= 2'h0;
            bud_reg <= 32'h0;
            over_reg <= 1'b0;
            info4_reg <= 1'b0;
            up_valid_reg <= 1'b0;
            up_word_reg <= '0;
            fifo_mem_reg[0] <= '0;
            fifo_mem_reg[1] <= '0;
            wr_idx_reg <= 1'b0;
            rd_idx_reg <= 1'b0;
            fill_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            conf_reg <= conf_next;
            bud_reg <= bud_next;
            over_reg <= over_next;
            info4_reg <= info4_next;
            up_valid_reg <= up_valid_next;
            up_word_reg <= up_word_next;
            fifo_mem_reg <= fifo_mem_next;
            wr_idx_reg <= wr_idx_next;
            rd_idx_reg <= rd_idx_next;
            fill_reg <= fill_next;
        end
    end

    assign tx_taken = !looped && up_acc;
    assign te_valid = head_valid;
    assign te_bd = head.bd;
    assign te_info4 = info4_reg;
    assign synchronised = !(st_reg inside {CUST_IDLE_STATE, CUST_ACQUIRING_STATE});
    assign loop_closed = looped;
    assign budget_overrun = over_reg;
endmodule

// file: hdl/lac_exchange_end.sv
// exchange side transceiver activation and loopback state machine
`timescale 1ns/1ps
module lac_exchange_end #(
    parameter logic [31:0] P_SILENCE_CYC = lac_pkg::SILENCE_CYC,
    parameter logic [31:0] P_LAST_SIGNAL_CYC = lac_pkg::LAST_SIGNAL_CYC,
    parameter logic [31:0] P_WARM_BUDGET_CYC = lac_pkg::WARM_SIDE_CYC,
    parameter logic [31:0] P_COLD_BUDGET_CYC = lac_pkg::COLD_EXCH_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    lac_link_if.exch link,
    input wire logic activate_access_primitive,
    input wire logic deactivate_access_primitive,
    input wire logic activate_loopback_primitive,
    input wire logic return_normal_req,
    input wire logic warm_start,
    input wire logic [lac_pkg::BD_W-1:0] tx_bd,
    input wire logic [lac_pkg::M_W-1:0] tx_maint,
    output logic tx_taken,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [lac_pkg::BD_W-1:0] rx_bd,
    output logic [lac_pkg::M_W-1:0] rx_maint,
    output logic frame_word_sync_event,
    output logic access_activated,
    output logic loopback_set,
    output logic access_deactivated_primitive,
    output logic budget_overrun
);
    import lac_pkg::*;

    typedef enum logic [2:0] {
        EXCHANGE_IDLE_STATE,
        EXCHANGE_TRAINING_STATE,
        EXCHANGE_AWAITING_TRANSPARENCY_STATE,
        EXCHANGE_ACTIVE_STATE,
        EXCHANGE_LOOPBACK_STATE,
        EXCHANGE_DEACTIVATING_STATE,
        EXCHANGE_PENDING_DEACTIVATED_STATE
    } lac_ex_state_t;

    lac_ex_state_t st_reg, st_next;
    logic [31:0] tmr_reg, tmr_next;
    logic [31:0] bud_reg, bud_next;
    logic [1:0] cnt_reg, cnt_next;
    logic sync_reg, sync_next;
    logic deact_reg, deact_next;
    logic over_reg, over_next;
    logic dn_valid_reg, dn_valid_next;
    lac_word_t dn_word_reg, dn_word_next;
    logic up_acc, up_present, up_active, dn_acc;
    logic [31:0] budget;

    assign link.up_ready = rx_ready;
    assign up_acc = link.up_valid && link.up_ready;
    assign up_present = up_acc && (link.up_word.sig != LAC_SIG_NONE);
    assign up_active = up_acc && (link.up_word.sig == LAC_SIG_ACTIVE);
    assign dn_acc = link.dn_valid && link.dn_ready;
    // no in-service limit is enforced, the overrun pulse is only reported
    assign budget = warm_start ? P_WARM_BUDGET_CYC : P_COLD_BUDGET_CYC;

    always_comb begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        bud_next = bud_reg;
        cnt_next = cnt_reg;
        sync_next = 1'b0;
        deact_next = 1'b0;
        over_next = 1'b0;
        if (st_reg == EXCHANGE_TRAINING_STATE && bud_reg != 32'hffffffff) begin
            bud_next = bud_reg + 32'h1;
            over_next = (bud_reg == budget);
        end
        case (st_reg)
            EXCHANGE_IDLE_STATE: begin
                if (activate_access_primitive || activate_loopback_primitive) begin
                    st_next = EXCHANGE_TRAINING_STATE;
                    tmr_next = 32'h0;
                    bud_next = 32'h0;
                    cnt_next = 2'h0;
                end
            end
            EXCHANGE_TRAINING_STATE: begin
                if (up_present) begin
                    tmr_next = 32'h0;
                    cnt_next = cnt_reg + 2'h1;
                    if (cnt_reg == SYNC_WORDS - 2'h1) begin
                        st_next = EXCHANGE_AWAITING_TRANSPARENCY_STATE;
                        sync_next = 1'b1;
                    end
                end else begin
                    if (up_acc) begin
                        cnt_next = 2'h0;
                    end
                    tmr_next = tmr_reg + 32'h1;
                    if (tmr_reg == P_SILENCE_CYC) begin
                        st_next = EXCHANGE_IDLE_STATE;
                    end
                end
            end
            EXCHANGE_AWAITING_TRANSPARENCY_STATE: begin
                if (deactivate_access_primitive && warm_start) begin
                    st_next = EXCHANGE_DEACTIVATING_STATE;
                    cnt_next = 2'h0;
                end else if (up_active && link.up_word.layer2_ready_bit) begin
                    if (activate_loopback_primitive) begin
                        st_next = EXCHANGE_LOOPBACK_STATE;
                    end else if (activate_access_primitive) begin
                        st_next = EXCHANGE_ACTIVE_STATE;
                    end
                end
            end
            EXCHANGE_ACTIVE_STATE: begin
                if (deactivate_access_primitive && warm_start) begin
                    st_next = EXCHANGE_DEACTIVATING_STATE;
                    cnt_next = 2'h0;
                end else if (up_active && !link.up_word.layer2_ready_bit) begin
                    st_next = EXCHANGE_AWAITING_TRANSPARENCY_STATE;
                end
            end
            EXCHANGE_LOOPBACK_STATE: begin
                if (return_normal_req) begin
                    st_next = EXCHANGE_AWAITING_TRANSPARENCY_STATE;
                end else if (up_active && !link.up_word.layer2_ready_bit) begin
                    st_next = EXCHANGE_AWAITING_TRANSPARENCY_STATE;
                end
            end
            EXCHANGE_DEACTIVATING_STATE: begin
                if (dn_acc && !link.dn_word.keep_on) begin
                    cnt_next = cnt_reg + 2'h1;
                    if (cnt_reg == DEACT_WORDS - 2'h1) begin
                        st_next = EXCHANGE_PENDING_DEACTIVATED_STATE;
                        tmr_next = 32'h0;
                    end
                end
            end
            EXCHANGE_PENDING_DEACTIVATED_STATE: begin
                tmr_next = tmr_reg + 32'h1;
                if (tmr_reg == P_LAST_SIGNAL_CYC - 32'h1) begin
                    st_next = EXCHANGE_IDLE_STATE;
                    deact_next = 1'b1;
                end
            end
            default: begin
                st_next = EXCHANGE_IDLE_STATE;
            end
        endcase
    end

    // downstream word only changes when the last one was taken
    always_comb begin
        dn_valid_next = dn_valid_reg;
        dn_word_next = dn_word_reg;
        if (!dn_valid_reg || link.dn_ready) begin
            dn_valid_next = !(st_next inside {EXCHANGE_IDLE_STATE, EXCHANGE_PENDING_DEACTIVATED_STATE});
            dn_word_next.sig = (st_next inside {EXCHANGE_ACTIVE_STATE, EXCHANGE_LOOPBACK_STATE,
                EXCHANGE_DEACTIVATING_STATE}) ? LAC_SIG_ACTIVE : LAC_SIG_SYNC;
            dn_word_next.layer2_ready_bit = st_next inside {EXCHANGE_ACTIVE_STATE, EXCHANGE_LOOPBACK_STATE};
            dn_word_next.keep_on = (st_next != EXCHANGE_DEACTIVATING_STATE);
            dn_word_next.loop_cmd = activate_loopback_primitive &&
                (st_next inside {EXCHANGE_AWAITING_TRANSPARENCY_STATE, EXCHANGE_LOOPBACK_STATE});
            dn_word_next.bd = tx_bd;
            dn_word_next.maint = tx_maint;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_reg <= EXCHANGE_IDLE_STATE;
            tmr_reg <= 32'h0;
            bud_reg <= 32'h0;
            cnt_reg <= 2'h0;
            sync_reg <= 1'b0;
            deact_reg <= 1'b0;
            over_reg <= 1'b0;
            dn_valid_reg <= 1'b0;
            dn_word_reg <= '0;
        end else begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            bud_reg <= bud_next;
            cnt_reg <= cnt_next;
            sync_reg <= sync_next;
            deact_reg <= deact_next;
            over_reg <= over_next;
            dn_valid_reg <= dn_valid_next;
            dn_word_reg <= dn_word_next;
        end
    end

    assign link.dn_valid = dn_valid_reg;
    assign link.dn_word = dn_word_reg;
    assign tx_taken = dn_acc;
    assign rx_valid = link.up_valid;
    assign rx_bd = link.up_word.bd;
    assign rx_maint = link.up_word.maint;
    assign frame_word_sync_event = sync_reg;
    assign access_activated = (st_reg == EXCHANGE_ACTIVE_STATE) || (st_reg == EXCHANGE_LOOPBACK_STATE);
    assign loopback_set = (st_reg == EXCHANGE_LOOPBACK_STATE);
    assign access_deactivated_primitive = deact_reg;
    assign budget_overrun = over_reg;
endmodule

// file: hdl/lac_link_if.sv
// line link between exchange end and customer end
`timescale 1ns/1ps
interface lac_link_if;
    logic dn_valid;
    logic dn_ready;
    lac_pkg::lac_word_t dn_word;
    logic up_valid;
    logic up_ready;
    lac_pkg::lac_word_t up_word;

    modport exch (
        output dn_valid,
        output dn_word,
        input dn_ready,
        input up_valid,
        input up_word,
        output up_ready
    );

    modport cust (
        input dn_valid,
        input dn_word,
        output dn_ready,
        output up_valid,
        output up_word,
        input up_ready
    );
endinterface

// file: hdl/lac_pkg.sv
// constants, types and link word layout for loopback activation control
// How it works
// - confirmed loop request: customer upstream goes active
// - customer raises layer2 ready with that switch
// - close loop only after downstream becomes active
// - looped B/D copy downstream, maintenance bits own
// - looped data to terminal, info4 with upstream switch
// - idle terminal keeps info2, no wake-up
// - loop command only after exchange frame sync
// - exchange goes active after upstream active, ready
// - exchange sends sync until transparency exists
// - loop release returns exchange to awaiting transparency
// - ready bit zero in active/loop: awaiting
// - synchronised customer sends active only when transparent or on a confirmed loop request
// - training silence over 480 ms returns idle
// - warm start 300 ms, 150 ms each
// - cold start 15 s, customer 5, exchange 10
// - start-up measured from wake until frame sync
// - cold units stay up after loop release
// - warm deactivate: deactivating, timer, deactivated report
package lac_pkg;
    localparam int BD_W = 18;
    localparam int M_W = 6;

    typedef enum logic [1:0] {
        LAC_SIG_NONE,
        LAC_SIG_SYNC,
        LAC_SIG_ACTIVE
    } lac_sig_t;

    // one frame word on the line, either direction
    typedef struct packed {
        lac_sig_t sig;
        logic layer2_ready_bit;
        logic keep_on;
        logic loop_cmd;
        logic [BD_W-1:0] bd;
        logic [M_W-1:0] maint;
    } lac_word_t;

    localparam longint unsigned CLK_KHZ = 64'd200000;
    localparam longint unsigned SILENCE_MS = 64'd480;
    localparam longint unsigned LAST_SIGNAL_MS = 64'd40;
    localparam longint unsigned WARM_TOTAL_MS = 64'd300;
    localparam longint unsigned WARM_SIDE_MS = WARM_TOTAL_MS / 64'd2;
    localparam longint unsigned COLD_TOTAL_MS = 64'd15000;
    localparam longint unsigned COLD_CUST_MS = 64'd5000;
    localparam longint unsigned COLD_EXCH_MS = COLD_TOTAL_MS - COLD_CUST_MS;

    localparam logic [31:0] SILENCE_CYC = 32'(SILENCE_MS * CLK_KHZ);
    localparam logic [31:0] LAST_SIGNAL_CYC = 32'(LAST_SIGNAL_MS * CLK_KHZ);
    localparam logic [31:0] WARM_SIDE_CYC = 32'(WARM_SIDE_MS * CLK_KHZ);
    localparam logic [31:0] COLD_CUST_CYC = 32'(COLD_CUST_MS * CLK_KHZ);
    localparam logic [31:0] COLD_EXCH_CYC = 32'(COLD_EXCH_MS * CLK_KHZ);

    localparam logic [1:0] SYNC_WORDS = 2'h3;
    localparam logic [1:0] CONFIRM_WORDS = 2'h3;
    localparam logic [1:0] DEACT_WORDS = 2'h3;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage

// file: test/lac_monitor.sv
// link checker: assertions on the line words between both ends
`timescale 1ns/1ps
module lac_monitor #(
    parameter logic [31:0] P_SILENCE_CYC = 32'd200
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic dn_valid,
    input wire logic dn_ready,
    input wire lac_pkg::lac_word_t dn_word,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire lac_pkg::lac_word_t up_word
);
    import lac_pkg::*;
    logic up_take;
    logic [1:0] sync_reg, sync_next, off_reg, off_next;
    logic seen_reg, seen_next;
    logic [31:0] sil_reg, sil_next;
    assign up_take = up_valid && up_ready;
    // counts are loose on purpose, so they err on the side of no false alarm
    always_comb begin
        sync_next = sync_reg;
        off_next = off_reg;
        seen_next = seen_reg || (up_take && up_word.sig == LAC_SIG_ACTIVE && up_word.layer2_ready_bit);
        sil_next = (dn_valid && sync_reg != 2'h3 && !up_take) ? sil_reg + 32'h1 : 32'h0;
        if (up_take && up_word.sig != LAC_SIG_NONE && sync_reg != 2'h3) begin
            sync_next = sync_reg + 2'h1;
        end
        if (dn_valid && dn_ready && !dn_word.keep_on && off_reg != 2'h3) begin
            off_next = off_reg + 2'h1;
        end
        if (!dn_valid) begin
            sync_next = 2'h0;
            off_next = 2'h0;
            seen_next = 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync_reg <= 2'h0;
            off_reg <= 2'h0;
            seen_reg <= 1'b0;
            sil_reg <= 32'h0;
        end else begin
            sync_reg <= sync_next;
            off_reg <= off_next;
            seen_reg <= seen_next;
            sil_reg <= sil_next;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence s_dn_stall;
        dn_valid && !dn_ready;
    endsequence
    sequence s_off_done;
        off_reg == 2'h3;
    endsequence
    a_dn_hold: assert property (s_dn_stall |=> dn_valid && $stable(dn_word)) else $error("dn word moved");
    a_dn_ready_active: assert property (dn_valid && dn_word.layer2_ready_bit |-> dn_word.sig == LAC_SIG_ACTIVE)
        else $error("dn ready bit on sync");
    a_dn_active_confirmed: assert property (dn_valid && dn_word.sig == LAC_SIG_ACTIVE && dn_word.keep_on |-> seen_reg)
        else $error("dn active unconfirmed");
    a_loop_after_sync: assert property (dn_valid && dn_word.loop_cmd |-> sync_reg == 2'h3)
        else $error("loop command early");
    a_up_ready_active: assert property (up_valid && up_word.layer2_ready_bit |-> up_word.sig == LAC_SIG_ACTIVE)
        else $error("up ready bit on sync");
    a_deact_drop: assert property (s_off_done |-> ##[0:2] !dn_valid) else $error("dn not released");
    a_training_silence: assert property (sil_reg < P_SILENCE_CYC + 32'h4) else $error("silence ignored");
    a_up_sync_hold: assert property (up_valid && !up_ready && up_word.sig == LAC_SIG_SYNC |=> $stable(up_word))
        else $error("up word moved");
endmodule

// file: test/testbench.sv
// self-checking bench joining the exchange end and the customer end
`timescale 1ns/1ps
module testbench;
    import lac_pkg::*;
    typedef struct {logic t; logic l; logic a; logic f;} lac_row_t;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic act = 1'b0, deact = 1'b0, lpb = 1'b0, rtn = 1'b0, warm = 1'b1, rxr = 1'b0;
    logic term = 1'b0, l2 = 1'b0, ter = 1'b0, len = 1'b1;
    logic [BD_W-1:0] xbd = 18'h2a5c3, cbd = 18'h1b2e4;
    logic [BD_W-1:0] tebd;
    logic [BD_W-1:0] rx_bd;
    logic [M_W-1:0] rx_maint;
    logic fsync, acc, lset, dea, info4, lclose, xov, cov, rxv, tev, csync, xov_s = 1'b0, cov_s = 1'b0;
    int miscompares = 0, checked = 0, cyc = 0, i;
    lac_row_t rows[4] = '{'{0, 0, 0, 0}, '{1, 0, 0, 0}, '{0, 1, 0, 0}, '{1, 1, 1, 1}};
    always #2.5 clk_sys = ~clk_sys;
    lac_link_if i_lac_link_if();
    lac_monitor #(.P_SILENCE_CYC(32'd200)) i_lac_monitor(.clk_sys(clk_sys), .reset_n(reset_n),
        .dn_valid(i_lac_link_if.dn_valid), .dn_ready(i_lac_link_if.dn_ready), .dn_word(i_lac_link_if.dn_word),
        .up_valid(i_lac_link_if.up_valid), .up_ready(i_lac_link_if.up_ready), .up_word(i_lac_link_if.up_word));
    lac_exchange_end #(.P_SILENCE_CYC(32'd200), .P_LAST_SIGNAL_CYC(32'd50), .P_WARM_BUDGET_CYC(32'd100),
        .P_COLD_BUDGET_CYC(32'd300)) i_lac_exchange_end(.clk_sys(clk_sys), .reset_n(reset_n),
        .link(i_lac_link_if.exch), .activate_access_primitive(act), .deactivate_access_primitive(deact),
        .activate_loopback_primitive(lpb), .return_normal_req(rtn), .warm_start(warm), .tx_bd(xbd),
        .tx_maint(6'h2a), .tx_taken(), .rx_ready(rxr), .rx_valid(rxv), .rx_bd(rx_bd), .rx_maint(rx_maint),
        .frame_word_sync_event(fsync), .access_activated(acc), .loopback_set(lset),
        .access_deactivated_primitive(dea), .budget_overrun(xov));
    lac_customer_end #(.P_WARM_BUDGET_CYC(32'd100), .P_COLD_BUDGET_CYC(32'd300)) i_lac_customer_end(
        .clk_sys(clk_sys), .reset_n(reset_n), .link(i_lac_link_if.cust), .loop_enable(len), .term_active(term),
        .layer2_ready(l2), .warm_start(warm), .tx_bd(cbd), .tx_maint(6'h15), .tx_taken(), .te_valid(tev),
        .te_ready(ter), .te_bd(tebd), .te_info4(info4), .synchronised(csync), .loop_closed(lclose),
        .budget_overrun(cov));
    task automatic chk(input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // the whole run is near 400 cycles; the ceiling leaves ample slack
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        xov_s <= xov_s | xov;
        cov_s <= cov_s | cov;
        if (cyc == 6000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        act <= 1'b1;
        @(negedge clk_sys);
        chk(i_lac_link_if.dn_valid, 1'b0);
        // a long stall keeps the customer acquiring past its warm budget
        repeat (120) @(negedge clk_sys);
        chk(i_lac_link_if.dn_ready, 1'b0);
        @(posedge clk_sys);
        ter <= 1'b1;
        // upstream never accepted, so training sees only silence
        for (i = 0; i < 300 && i_lac_link_if.dn_valid; i++) @(negedge clk_sys);
        chk(i_lac_link_if.dn_valid, 1'b0);
        chk(xov_s, 1'b1);
        chk(cov_s, 1'b1);
        chk(csync, 1'b1);
        @(posedge clk_sys);
        rxr <= 1'b1;
        for (i = 0; i < 300 && fsync !== 1'b1; i++) @(negedge clk_sys);
        chk(fsync, 1'b1);
        chk(rx_bd === cbd, 1'b1);
        @(posedge clk_sys);
        lpb <= 1'b1;
        for (i = 0; i < 200 && lclose !== 1'b1; i++) @(negedge clk_sys);
        chk(lclose, 1'b1);
        chk(lset, 1'b1);
        chk(info4, 1'b0);
        repeat (10) @(negedge clk_sys);
        chk(rx_bd === xbd, 1'b1);
        chk(rx_maint === 6'h15, 1'b1);
        chk(rxv, 1'b1);
        chk(tev, 1'b1);
        chk(tebd === xbd, 1'b1);
        @(posedge clk_sys);
        term <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(info4, 1'b1);
        @(posedge clk_sys);
        len <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(lclose, 1'b0);
        chk(lset, 1'b1);
        @(posedge clk_sys);
        len <= 1'b1;
        for (i = 0; i < 40 && lclose !== 1'b1; i++) @(negedge clk_sys);
        chk(lclose, 1'b1);
        @(posedge clk_sys);
        term <= 1'b0;
        lpb <= 1'b0;
        rtn <= 1'b1;
        deact <= 1'b1;
        warm <= 1'b1;
        act <= 1'b0;
        for (i = 0; i < 20 && lset; i++) @(negedge clk_sys);
        chk(lset, 1'b0);
        for (i = 0; i < 200 && dea !== 1'b1; i++) @(negedge clk_sys);
        chk(dea, 1'b1);
        @(posedge clk_sys);
        rtn <= 1'b0;
        deact <= 1'b0;
        warm <= 1'b0;
        act <= 1'b1;
        for (i = 0; i < 300 && fsync !== 1'b1; i++) @(negedge clk_sys);
        chk(fsync, 1'b1);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            term <= rows[i].t;
            l2 <= rows[i].l;
            repeat (20) @(negedge clk_sys);
            chk(acc, rows[i].a);
            chk(info4, rows[i].f);
        end
        report_and_stop();
    end
endmodule
